// ### verilog/peripheral_interrupt_sources_status.v
// Function
// [R01] Transmit holding empty flag sets on character move; requests only when enabled.
// [R02] Transmit done sets when both registers empty, no break or idle; gated by enable.
// [R03] Receive full sets on character handover; requests receive interrupt only when enabled.
// [R04] Idle flag sets after ten consecutive ones on receive pin; gated by enable.
// [R05] Overrun sets when a character completes before the previous one was read.
// [R06] Noise flag sets on noise in any start, data or stop bit.
// [R07] Framing fault sets when the stop bit position samples low.
// [R08] Parity flag sets on parity mismatch in incoming data.
// [R09] Serial fault request is the OR of four enabled error flags.
// [R10] Low keypad pin latches a request that stays after the pin rises.
// [R11] With converter enable, each completion requests interrupt; completion bit not a flag.
// [R12] Timebase flag sets at chain rollover at selected rate; requests only when enabled.
// [R13] Writing one to timebase acknowledge clears the pending timebase flag.
// [R14] Pending flags 1 to 16 map to the listed sources, flag 7 reserved.
// [R15] Each pending flag reads one while its source requests; reset and software none.
// [R16] Low status register holds flags 6 to 1; bits 1 and 0 read zero.
// [R17] Middle status register holds flags 14 to 7; bit 0 reads zero.
// [R18] High status register holds flags 16 and 15; bits 7 to 2 zero.
// [R19] Global mask blocks every listed source; lowest flag number has highest priority.
// [R20] Status register writes are ignored; flags follow their sources every cycle.
`timescale 1ns/1ps
`include "int_sources_defs.vh"

module peripheral_interrupt_sources_status #(
  parameter KEYPAD_PINS = 5,
  parameter IDLE_BITS = 10
) (
  input wire sys_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire extPinReq,
  input wire pllReq,
  input wire tim1Ch0Req,
  input wire tim1Ch1Req,
  input wire tim1OvfReq,
  input wire tim2Ch0Req,
  input wire tim2OvfReq,
  input wire spiRxReq,
  input wire spiTxReq,
  input wire txCharMoved,
  input wire txShiftEmpty,
  input wire txDataEmpty,
  input wire txBreakIdleGen,
  input wire rxCharDone,
  input wire rxDataRead,
  input wire rxBitTick,
  input wire rxdPin,
  input wire rxStopSample,
  input wire rxNoiseSeen,
  input wire rxParityMismatch,
  input wire convDone,
  input wire convAck,
  input wire [KEYPAD_PINS-1:0] keypad_input_pins,
  output wire cpuIrq,
  output reg [4:0] irqSource_q
);

  reg [7:0] serialEn_q;
  reg [7:0] serialFlags_q;
  reg [7:0] miscCtrl_q;
  reg [3:0] idleCount_q;
  reg rxdMeta_q;
  reg rxdSync_q;
  reg [KEYPAD_PINS-1:0] kbdMeta_q;
  reg [KEYPAD_PINS-1:0] kbdSync_q;
  reg keypadLatch_q;
  reg convPending_q;
  reg [`TB_WIDTH-1:0] tbCount_q;
  reg timebase_flag_q;
  reg [31:0] readData_d;
  reg [4:0] irqSource_d;
  reg addrHit;
  integer i;

  wire setupPhase = psel & ~penable;
  wire writeAccess = psel & penable & pwrite;
  wire wrSerialStat = writeAccess & (paddr == `ADDR_SERIAL_STAT);
  wire wrMiscStat = writeAccess & (paddr == `ADDR_MISC_STAT);
  wire [7:0] serialClear = wrSerialStat ? pwdata[7:0] : 8'h00;
  wire timebase_ack = wrMiscStat & pwdata[`MS_TIMEBASE];
  wire keypadAck = wrMiscStat & pwdata[`MS_KEYPAD];
  wire converterAck = (wrMiscStat & pwdata[`MS_CONVERTER]) | convAck;

  wire converter_int_en = miscCtrl_q[`MC_CONV_EN];
  wire timebase_int_en = miscCtrl_q[`MC_TB_EN];
  wire [2:0] timebase_rate_sel = miscCtrl_q[`MC_RATE_MSB:`MC_RATE_LSB];
  wire globalMask = miscCtrl_q[`MC_GLOBAL_MASK];

  // Zero wait states: read data is captured in the setup phase.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addrHit;

  always @* begin
    case (paddr)
      `ADDR_PENDING_LOW, `ADDR_PENDING_MID, `ADDR_PENDING_HIGH,
      `ADDR_SERIAL_EN, `ADDR_SERIAL_STAT, `ADDR_MISC_CTRL, `ADDR_MISC_STAT: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  // Receive pin and keypad pins come from outside and are synchronised first.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxdMeta_q <= 1'b1;
      rxdSync_q <= 1'b1;
    end else begin
      rxdMeta_q <= rxdPin;
      rxdSync_q <= rxdMeta_q;
    end
  end

  genvar k;
  generate
    for (k = 0; k < KEYPAD_PINS; k = k + 1) begin : gKeypadSync
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          kbdMeta_q[k] <= 1'b1;
          kbdSync_q[k] <= 1'b1;
        end else begin
          kbdMeta_q[k] <= keypad_input_pins[k];
          kbdSync_q[k] <= kbdMeta_q[k];
        end
      end
    end
  endgenerate

  // Consecutive ones on the receive line; saturates so the flag sets only once per idle run.
  wire idleReached = rxBitTick & rxdSync_q & (idleCount_q == IDLE_BITS[3:0] - 4'h1);
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      idleCount_q <= 4'h0;
    end else if (rxBitTick) begin
      if (!rxdSync_q) begin
        idleCount_q <= 4'h0;
      end else if (idleCount_q != IDLE_BITS[3:0]) begin
        idleCount_q <= idleCount_q + 4'h1;
      end
    end
  end

  // Serial event sources; a set in the same cycle as a clear wins.
  wire [7:0] serialSet;
  assign serialSet[`SB_TX_EMPTY] = txCharMoved; // [R01]
  assign serialSet[`SB_TX_DONE] = txShiftEmpty & txDataEmpty & ~txBreakIdleGen; // [R02]
  assign serialSet[`SB_RX_FULL] = rxCharDone; // [R03]
  assign serialSet[`SB_IDLE] = idleReached; // [R04]
  // Overrun needs the full flag set and no data read in this same cycle; a same-cycle read prevents it.
  assign serialSet[`SB_OVERRUN] = rxCharDone & serialFlags_q[`SB_RX_FULL] & ~rxDataRead; // [R05]
  assign serialSet[`SB_NOISE] = rxNoiseSeen; // [R06]
  assign serialSet[`SB_FRAMING] = rxStopSample & ~rxdSync_q; // [R07]
  assign serialSet[`SB_PARITY] = rxParityMismatch; // [R08]

  wire [7:0] serialClrAll = serialClear | {7'h00, 1'b0} |
    ({8{rxDataRead}} & (8'h01 << `SB_RX_FULL));

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      serialFlags_q <= 8'h00;
    end else begin
      serialFlags_q <= serialSet | (serialFlags_q & ~serialClrAll);
    end
  end

  wire [7:0] serialReq = serialFlags_q & serialEn_q;
  wire sciTxReq = serialReq[`SB_TX_EMPTY] | serialReq[`SB_TX_DONE]; // [R01] [R02]
  wire sciRxReq = serialReq[`SB_RX_FULL] | serialReq[`SB_IDLE]; // [R03] [R04]
  wire sciErrReq = serialReq[`SB_OVERRUN] | serialReq[`SB_NOISE] |
    serialReq[`SB_FRAMING] | serialReq[`SB_PARITY]; // [R09]

  // Keypad latch holds after the pin returns high until acknowledged.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      keypadLatch_q <= 1'b0;
    end else begin
      keypadLatch_q <= ~(&kbdSync_q) | (keypadLatch_q & ~keypadAck); // [R10]
    end
  end

  // Converter completion is one store; the enable decides whether it reads as a
  // completion bit or as an interrupt request.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      convPending_q <= 1'b0;
    end else begin
      convPending_q <= convDone | (convPending_q & ~converterAck);
    end
  end
  wire convReq = convPending_q & converter_int_en; // [R11]
  wire conversion_done_bit = convPending_q & ~converter_int_en; // [R11]

  // Timebase chain: a larger rate select picks a shorter period.
  wire [4:0] tbTap = 5'd`TB_TOP_TAP - {1'b0, timebase_rate_sel, 1'b0};
  wire [`TB_WIDTH-1:0] tbMask = ({`TB_WIDTH{1'b1}} >> (5'd`TB_TOP_TAP - tbTap));
  wire tbRollover = ((tbCount_q & tbMask) == tbMask);
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tbCount_q <= {`TB_WIDTH{1'b0}};
      timebase_flag_q <= 1'b0;
    end else begin
      tbCount_q <= tbCount_q + {{(`TB_WIDTH-1){1'b0}}, 1'b1};
      timebase_flag_q <= tbRollover | (timebase_flag_q & ~timebase_ack); // [R12] [R13]
    end
  end
  wire tbReq = timebase_flag_q & timebase_int_en; // [R12]

  // Pending flags indexed 1 to 16; index 7 is reserved and index 0 unused.
  wire [16:0] pendingFlag = {tbReq, convReq, keypadLatch_q, sciTxReq, sciRxReq, sciErrReq,
    spiTxReq, spiRxReq, tim2OvfReq, 1'b0, tim2Ch0Req, tim1OvfReq, tim1Ch1Req, tim1Ch0Req,
    pllReq, extPinReq, 1'b0}; // [R14] [R15]
  wire [7:0] pending_flags_low = {pendingFlag[6:1], 2'b00}; // [R16]
  wire [7:0] pending_flags_mid = {pendingFlag[14:8], 1'b0}; // [R17]
  wire [7:0] pending_flags_high = {6'h00, pendingFlag[16:15]}; // [R18]

  // Lowest numbered pending flag wins; the global mask blocks the request.
  always @* begin
    irqSource_d = 5'h00;
    for (i = 16; i >= 1; i = i - 1) begin
      if (pendingFlag[i]) begin
        irqSource_d = i[4:0]; // [R19]
      end
    end
  end
  assign cpuIrq = (|pendingFlag) & ~globalMask; // [R19]

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqSource_q <= 5'h00;
    end else begin
      irqSource_q <= globalMask ? 5'h00 : irqSource_d; // [R19]
    end
  end

  // Writable control registers; pending status registers have no write path.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      serialEn_q <= `SERIAL_EN_RESET;
      miscCtrl_q <= `MISC_CTRL_RESET;
    end else if (writeAccess) begin
      if (paddr == `ADDR_SERIAL_EN) begin
        serialEn_q <= pwdata[7:0];
      end
      if (paddr == `ADDR_MISC_CTRL) begin
        miscCtrl_q <= {pwdata[7], 2'b00, pwdata[4:0]};
      end
    end
  end

  always @* begin
    case (paddr)
      `ADDR_PENDING_LOW: readData_d = {24'h000000, pending_flags_low}; // [R20]
      `ADDR_PENDING_MID: readData_d = {24'h000000, pending_flags_mid}; // [R20]
      `ADDR_PENDING_HIGH: readData_d = {24'h000000, pending_flags_high}; // [R20]
      `ADDR_SERIAL_EN: readData_d = {24'h000000, serialEn_q};
      `ADDR_SERIAL_STAT: readData_d = {24'h000000, serialFlags_q};
      `ADDR_MISC_CTRL: readData_d = {24'h000000, miscCtrl_q};
      `ADDR_MISC_STAT: readData_d = {29'h00000000, conversion_done_bit, keypadLatch_q,
        timebase_flag_q};
      default: readData_d = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (setupPhase) begin
      prdata <= readData_d;
    end
  end

endmodule

// ### verilog/int_sources_defs.vh
`ifndef INT_SOURCES_DEFS_VH
`define INT_SOURCES_DEFS_VH

// Register byte addresses.
`define ADDR_PENDING_LOW 12'h000
`define ADDR_PENDING_MID 12'h004
`define ADDR_PENDING_HIGH 12'h008
`define ADDR_SERIAL_EN 12'h00c
`define ADDR_SERIAL_STAT 12'h010
`define ADDR_MISC_CTRL 12'h014
`define ADDR_MISC_STAT 12'h018

// Serial enable and status bit positions (same layout in both registers).
`define SB_TX_EMPTY 0
`define SB_TX_DONE 1
`define SB_RX_FULL 2
`define SB_IDLE 3
`define SB_OVERRUN 4
`define SB_NOISE 5
`define SB_FRAMING 6
`define SB_PARITY 7

// Miscellaneous control register fields.
`define MC_CONV_EN 0
`define MC_TB_EN 1
`define MC_RATE_LSB 2
`define MC_RATE_MSB 4
`define MC_GLOBAL_MASK 7

// Miscellaneous status (read) and acknowledge (write one) bits.
`define MS_TIMEBASE 0
`define MS_KEYPAD 1
`define MS_CONVERTER 2

// Reset values.
`define SERIAL_EN_RESET 8'h00
`define MISC_CTRL_RESET 8'h80

// Line idle detection and timebase chain.
`define IDLE_BITS 4'ha
`define TB_WIDTH 16
`define TB_TOP_TAP 15

`endif

// ### verif/int_status_properties.sv
`timescale 1ns/1ps
module int_status_checker (
  input wire sys_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire extPinReq,
  input wire cpuIrq,
  input wire [4:0] irqSource_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire acc = psel && penable;
  wire rdAcc = acc && !pwrite;
  wire bad = paddr > 12'h018;
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && bad |-> pslverr)
    else $error("missing slave error");
  a_mapped_ok: assert property (acc && !bad |-> !pslverr)
    else $error("false slave error");
  a_unmapped_zero: assert property (rdAcc && bad |-> prdata == 32'h0)
    else $error("unmapped read data");
  a_upper_zero: assert property (rdAcc |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_low_fixed: assert property (rdAcc && paddr == 12'h000 |-> prdata[1:0] == 2'h0)
    else $error("low status fixed bits");
  a_mid_fixed: assert property (rdAcc && paddr == 12'h004 |-> !prdata[0])
    else $error("mid status fixed bit");
  a_high_fixed: assert property (rdAcc && paddr == 12'h008 |-> prdata[7:2] == 6'h0)
    else $error("high status fixed bits");
  a_read_hold: assert property (rdAcc |=> prdata == $past(prdata))
    else $error("read data moved");
  a_src_when_irq: assert property (cpuIrq |=> irqSource_q != 5'h00)
    else $error("request without source");
  a_src_when_quiet: assert property (!cpuIrq |=> irqSource_q == 5'h00)
    else $error("source without request");
  a_ext_first: assert property (extPinReq && cpuIrq |=> irqSource_q == 5'h01)
    else $error("pin source not first");
  a_src_legal: assert property (irqSource_q != 5'h07 && irqSource_q <= 5'h10)
    else $error("illegal source number");
  cover property (cpuIrq ##1 !cpuIrq);
  cover property (acc && pslverr);
  cover property (irqSource_q == 5'h0e);
endmodule
bind peripheral_interrupt_sources_status int_status_checker chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .extPinReq(extPinReq),
  .cpuIrq(cpuIrq), .irqSource_q(irqSource_q));

// ### verif/serial_line_model.sv
`timescale 1ns/1ps
module serial_line_model (
  input wire sys_clk,
  input wire [1:0] lineMode,
  output reg rxdPin,
  output reg rxBitTick
);
  reg [1:0] div_q;
  initial begin
    div_q = 2'h0;
    rxdPin = 1'h1;
    rxBitTick = 1'h0;
  end
  // Mode 0 rests the line high with no bit times, 1 sends idle ones, 2 holds a break.
  always @(posedge sys_clk) begin
    div_q <= div_q + 2'h1;
    rxBitTick <= lineMode != 2'h0 && div_q == 2'h3;
    rxdPin <= lineMode != 2'h2;
  end
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [8:0] lvl = 9'h0;
  logic txM = 1'h0, txS = 1'h0, txD = 1'h0, rxC = 1'h0, rxN = 1'h0, rxP = 1'h0;
  logic rxSt = 1'h0, rxRd = 1'h0, brk = 1'h0, cDone = 1'h0, cAck = 1'h0;
  logic [4:0] keys = 5'h1f;
  logic [1:0] lineMode = 2'h0;
  wire [31:0] prdata;
  wire [4:0] irqSource_q;
  wire pready, pslverr, cpuIrq, rxdPin, rxBitTick;
  integer seed = 30, miscompares = 0, tests_run = 0, cyc = 0, i;
  always #12.5 sys_clk = ~sys_clk;
  serial_line_model line (.sys_clk(sys_clk), .lineMode(lineMode), .rxdPin(rxdPin),
    .rxBitTick(rxBitTick));
  peripheral_interrupt_sources_status uut (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .extPinReq(lvl[0]),
    .pllReq(lvl[1]), .tim1Ch0Req(lvl[2]), .tim1Ch1Req(lvl[3]), .tim1OvfReq(lvl[4]),
    .tim2Ch0Req(lvl[5]), .tim2OvfReq(lvl[6]), .spiRxReq(lvl[7]), .spiTxReq(lvl[8]),
    .txCharMoved(txM), .txShiftEmpty(txS), .txDataEmpty(txD), .txBreakIdleGen(brk),
    .rxCharDone(rxC), .rxDataRead(rxRd), .rxBitTick(rxBitTick), .rxdPin(rxdPin),
    .rxStopSample(rxSt), .rxNoiseSeen(rxN), .rxParityMismatch(rxP), .convDone(cDone),
    .convAck(cAck), .keypad_input_pins(keys), .cpuIrq(cpuIrq), .irqSource_q(irqSource_q));
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Waits on pready rather than assuming the zero-wait answer.
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  task rc(input [11:0] a, input [31:0] e);
    apb(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  task ev(input integer k);
    case (k)
      0: txM <= 1'h1;
      1: {txS, txD} <= 2'h3;
      2: rxC <= 1'h1;
      3: begin lineMode <= 2'h1; repeat (50) @(posedge sys_clk); end
      4: begin rxC <= 1'h1; @(posedge sys_clk); rxC <= 1'h0; @(posedge sys_clk); rxC <= 1'h1; end
      5: rxN <= 1'h1;
      6: begin lineMode <= 2'h2; repeat (8) @(posedge sys_clk); rxSt <= 1'h1; end
      7: rxP <= 1'h1;
      8: cDone <= 1'h1;
      default: cAck <= 1'h1;
    endcase
    @(posedge sys_clk);
    {txM, txS, txD, rxC, rxN, rxSt, rxP, cDone, cAck} <= 9'h0;
    lineMode <= 2'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  function [4:0] first_src(input [8:0] v);
    first_src = 5'h0;
    for (int j = 8; j >= 0; j--) if (v[j]) first_src = j < 6 ? j + 1 : j + 2;
  endfunction
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(posedge sys_clk);
    rc(12'h00c, 32'h0);
    rc(12'h014, 32'h80);
    rc(12'h004, 32'h0);
    rc(12'h100, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    apb(1'h1, 12'h014, 32'h0);
    apb(1'h1, 12'h000, 32'hff);
    $display("done reset and map");
    for (i = 0; i < 9; i++) begin
      lvl <= i == 8 ? 9'h1ff : $random(seed);
      repeat (2) @(posedge sys_clk);
      rc(12'h000, {24'h0, lvl[5:0], 2'h0});
      rc(12'h004, {28'h0, lvl[8:6], 1'h0});
      chk("source", {27'h0, first_src(lvl)}, {27'h0, irqSource_q});
    end
    lvl <= 9'h0;
    $display("done level sources");
    for (i = 0; i < 8; i++) begin
      apb(1'h1, 12'h010, 32'hff);
      apb(1'h1, 12'h00c, 32'h1 << i);
      ev(i);
      rc(12'h010, 32'h1 << i | (i == 4 ? 32'h4 : 32'h0));
      #1 chk("source", i < 2 ? 32'hd : i < 4 ? 32'hc : 32'hb, {27'h0, irqSource_q});
      apb(1'h1, 12'h00c, 32'h0);
      rc(12'h004, 32'h0);
    end
    $display("done serial flags");
    keys <= 5'h0f;
    repeat (3) @(posedge sys_clk);
    keys <= 5'h1f;
    repeat (6) @(posedge sys_clk);
    rc(12'h004, 32'h80);
    apb(1'h1, 12'h018, 32'h2);
    rc(12'h004, 32'h0);
    ev(8);
    rc(12'h018, 32'h4);
    rc(12'h008, 32'h0);
    ev(9);
    apb(1'h1, 12'h014, 32'h1);
    ev(8);
    rc(12'h008, 32'h1);
    rc(12'h018, 32'h0);
    ev(9);
    $display("done keypad and converter");
    apb(1'h1, 12'h014, 32'h1c);
    rc(12'h008, 32'h0);
    apb(1'h1, 12'h014, 32'h1e);
    rc(12'h008, 32'h2);
    apb(1'h1, 12'h014, 32'h2);
    apb(1'h1, 12'h018, 32'h1);
    rc(12'h008, 32'h0);
    lvl <= 9'h41;
    repeat (3) @(posedge sys_clk);
    #1 chk("irq", 32'h1, {31'h0, cpuIrq});
    chk("source", 32'h1, {27'h0, irqSource_q});
    apb(1'h1, 12'h014, 32'h80);
    #1 chk("masked", 32'h0, {26'h0, cpuIrq, irqSource_q});
    $display("done timebase and mask");
    tally_and_finish;
  end
endmodule
